// ---- src/atw_pkg.sv ----
// Constants for the converter's two-wire slave interface
// Behaviour
// - Differential mode: polarity setting picks unipolar 0..ref or bipolar +-ref/2.
// - Unipolar with negative differential input gives an all-zero code.
// - Unipolar results are straight binary; bipolar results are two's complement.
// - Single-ended mode is always unipolar, whatever the polarity setting.
// - Device is slave only; master starts transfers and drives clock.
// - One bit per serial clock; each byte takes nine clocks with its acknowledge.
// - Data changes while clock is high are control conditions, not data.
// - Start is data falling with clock high; stop is data rising.
// - Repeated start keeps the bus active and keeps the speed mode.
// - Acknowledge pulls data low over the ninth clock; release means no.
// - When idle, wait for start plus slave address 0110110 before responding.
// - Address byte's last bit: zero is a write, one is a read.
// - A matching address byte is acknowledged for one clock.
// - Power-up uses fast/standard timing; high-speed mode is a later switch.
// - Master code 0000 1XXX is not acknowledged, then high-speed mode holds.
// - A stop condition always returns the device to fast/standard mode.
// - Written byte with MSB one is setup; MSB zero is configuration.
// - Master writes one or two bytes in any order; each is acknowledged.
// - Idle bus: both lines high, nobody pulls them low.
// - Polarity is setup bit 2: one bipolar, zero unipolar; zero at reset.
// - Input mode is configuration bit 0: one single-ended; one at reset.
package atw_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h36;
	localparam logic [3:0] MCODE_HIGH = 4'h0;
	localparam int MCODE_FLAG_BIT = 3;
	localparam int RW_BIT = 0;
	localparam int REG_SEL_BIT = 7;
	localparam int POL_BIT = 2;
	localparam int CFG_RST_BIT = 1;
	localparam int MODE_BIT = 0;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [7:0] SETUP_RESET = 8'h82;
	localparam logic [7:0] CONFIG_RESET = 8'h01;
	localparam logic POL_RESET = 1'b0;
	localparam logic MODE_RESET = 1'b1;
	localparam int CODE_W = 10;
	localparam int DIFF_W = 11;
	localparam logic [9:0] UNI_MAX = 10'h3FF;
	localparam logic [9:0] BIP_MAX = 10'h1FF;
	localparam logic [9:0] BIP_MIN = 10'h200;
	localparam logic [9:0] CODE_ZERO = 10'h000;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_ACK,
		ST_SKIP
	} atw_state_t;
endpackage

// ---- src/atw_scl_sampler.sv ----
// Link-clock side: samples the data line on each serial clock rise
module atw_scl_sampler (
	input wire logic scl_i,
	input wire logic reset_n_i,
	input wire logic sda_i,
	output logic bit_o,
	output logic toggle_o
);
	// Bit stays stable a whole serial period, so the toggle alone crosses
	// one bit per clock
	always_ff @(posedge scl_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bit_o <= 1'b0;
			toggle_o <= 1'b0;
		end else begin
			bit_o <= sda_i;
			toggle_o <= ~toggle_o;
		end
	end
endmodule

// ---- src/atw_slave.sv ----
// Two-wire slave engine, setup/configuration store and result coding
module atw_slave (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic signed [10:0] conv_diff_i,
	input wire logic conv_valid_i,
	output logic [9:0] result_o,
	output logic result_valid_o,
	output logic bipolar_active_o,
	output logic polarity_select_o,
	output logic input_mode_select_o,
	output logic [7:0] setup_byte_o,
	output logic [7:0] config_byte_o,
	output logic hs_mode_o,
	output logic bus_busy_o,
	output logic read_request_o,
	output logic addr_match_o
);
	// Link-domain outputs of the sampler
	logic samp_bit;
	logic samp_tog;

	// Synchroniser stages into clock_i
	logic scl_s1;
	logic scl_s2;
	logic scl_s3;
	logic sda_s1;
	logic sda_s2;
	logic sda_s3;
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;

	// Line events from the synchronised levels
	logic start_det;
	logic stop_det;
	logic scl_fall;
	logic bit_evt;
	logic ack_done;
	logic [7:0] next_byte;

	// Byte engine
	atw_pkg::atw_state_t state;
	atw_pkg::atw_state_t after_ack;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic do_ack;
	logic ack_clocked;
	logic hs_pend;

	// Write path and result coding
	logic wr_valid;
	logic [7:0] wr_byte;
	logic bipolar;

	// Sampling on the link's own clock keeps the bit exact at any rate
	atw_scl_sampler u_sampler (
		.scl_i(scl_i),
		.reset_n_i(reset_n_i),
		.sda_i(sda_i),
		.bit_o(samp_bit),
		.toggle_o(samp_tog)
	);

	// Two flops before any logic; third stage is only for edge finding
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
		end else begin
			tog_s1 <= samp_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
		end
	end

	assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
	assign scl_fall = scl_s3 & ~scl_s2;
	// Sampled bit is held a full serial period, safe to read on toggle
	assign bit_evt = tog_s2 ^ tog_s3;
	assign next_byte = {shreg[6:0], samp_bit};
	// Ninth clock has fallen, the acknowledge slot is over
	assign ack_done = (state == atw_pkg::ST_ACK) & scl_fall & ack_clocked;

	// True when a received byte is the high-speed master code
	function automatic logic atw_is_mcode(input logic [7:0] b);
		atw_is_mcode = (b[7:4] == atw_pkg::MCODE_HIGH)
			&& b[atw_pkg::MCODE_FLAG_BIT];
	endfunction

	// True when a received byte carries this slave's address
	function automatic logic atw_is_mine(input logic [7:0] b);
		atw_is_mine = (b[7:1] == atw_pkg::SLAVE_ADDR);
	endfunction

	// Byte engine; the device never drives the clock line
	// slave only
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= atw_pkg::ST_IDLE;
			after_ack <= atw_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			do_ack <= 1'b0;
			ack_clocked <= 1'b0;
			hs_pend <= 1'b0;
			sda_oe_o <= 1'b0;
			wr_valid <= 1'b0;
			wr_byte <= 8'h00;
			read_request_o <= 1'b0;
			addr_match_o <= 1'b0;
		end else begin
			// Pulses last a single cycle
			wr_valid <= 1'b0;
			addr_match_o <= 1'b0;
			// Line conditions outrank a bit event in the same cycle
			if (stop_det) begin
				state <= atw_pkg::ST_IDLE;
				sda_oe_o <= 1'b0;
				hs_pend <= 1'b0;
				read_request_o <= 1'b0;
			end else if (start_det) begin
				state <= atw_pkg::ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe_o <= 1'b0;
				hs_pend <= 1'b0;
				read_request_o <= 1'b0;
			end else begin
				case (state)
				atw_pkg::ST_IDLE: begin
					sda_oe_o <= 1'b0;
				end

				atw_pkg::ST_ADDR,
				atw_pkg::ST_DATA: begin
					if (bit_evt) begin
						shreg <= next_byte;
						// Eighth bit completes the byte
						if (bit_cnt == atw_pkg::LAST_DATA_BIT) begin
							bit_cnt <= 4'h0;
							ack_clocked <= 1'b0;
							state <= atw_pkg::ST_ACK;
							if (state == atw_pkg::ST_ADDR) begin
								if (atw_is_mine(next_byte)) begin
									do_ack <= 1'b1;
									addr_match_o <= 1'b1;
									if (next_byte[atw_pkg::RW_BIT]) begin
										after_ack <= atw_pkg::ST_SKIP;
										read_request_o <= 1'b1;
									end else begin
										after_ack <= atw_pkg::ST_DATA;
									end
								end else if (atw_is_mcode(next_byte)) begin
									do_ack <= 1'b0;
									hs_pend <= 1'b1;
									after_ack <= atw_pkg::ST_SKIP;
								end else begin
									do_ack <= 1'b0;
									after_ack <= atw_pkg::ST_SKIP;
								end
							end else begin
								do_ack <= 1'b1;
								after_ack <= atw_pkg::ST_DATA;
								wr_valid <= 1'b1;
								wr_byte <= next_byte;
							end
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end

				atw_pkg::ST_ACK: begin
					if (bit_evt) begin
						ack_clocked <= 1'b1;
					end
					// First fall opens the slot, the next one closes it
					if (scl_fall) begin
						if (ack_clocked) begin
							sda_oe_o <= 1'b0;
							state <= after_ack;
						end else begin
							sda_oe_o <= do_ack;
						end
					end
				end

				atw_pkg::ST_SKIP: begin
					// Result framing for reads is not served here
					sda_oe_o <= 1'b0;
				end

				default: begin
					state <= atw_pkg::ST_IDLE;
					sda_oe_o <= 1'b0;
				end
				endcase
			end
		end
	end

	// Speed mode: entered after master-code refusal, left only on stop
	// fast/standard from reset
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hs_mode_o <= 1'b0;
		end else if (stop_det) begin
			hs_mode_o <= 1'b0;
		// Waits for the slot to end, so the refusal runs at F/S timing
		end else if (ack_done && hs_pend) begin
			hs_mode_o <= 1'b1;
		end
	end

	// Bus activity between start and stop
	// A repeated start leaves it set
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus_busy_o <= 1'b0;
		end else if (stop_det) begin
			bus_busy_o <= 1'b0;
		end else if (start_det) begin
			bus_busy_o <= 1'b1;
		end
	end

	// Open-drain: only ever pulls low, never drives high
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	// Written bytes sorted by their top bit
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			polarity_select_o <= atw_pkg::POL_RESET;
			input_mode_select_o <= atw_pkg::MODE_RESET;
			setup_byte_o <= atw_pkg::SETUP_RESET;
			config_byte_o <= atw_pkg::CONFIG_RESET;
		end else if (wr_valid) begin
			if (wr_byte[atw_pkg::REG_SEL_BIT]) begin
				setup_byte_o <= wr_byte;
				polarity_select_o <= wr_byte[atw_pkg::POL_BIT];
				// Low reset bit restores configuration only
				if (!wr_byte[atw_pkg::CFG_RST_BIT]) begin
					config_byte_o <= atw_pkg::CONFIG_RESET;
					input_mode_select_o <= atw_pkg::MODE_RESET;
				end
			end else begin
				config_byte_o <= wr_byte;
				input_mode_select_o <= wr_byte[atw_pkg::MODE_BIT];
			end
		end
	end

	assign bipolar = polarity_select_o & ~input_mode_select_o;

	// Clamp a signed difference into the active code range
	function automatic logic [9:0] atw_format(
		input logic signed [10:0] d,
		input logic bip
	);
		logic signed [10:0] hi;
		logic signed [10:0] lo;
		hi = $signed({2'b00, atw_pkg::BIP_MAX[8:0]});
		lo = $signed({2'b11, atw_pkg::BIP_MIN[8:0]});
		if (bip) begin
			if (d > hi) begin
				atw_format = atw_pkg::BIP_MAX;
			end else if (d < lo) begin
				atw_format = atw_pkg::BIP_MIN;
			end else begin
				atw_format = d[9:0];
			end
		end else if (d[10]) begin
			atw_format = atw_pkg::CODE_ZERO;
		end else begin
			atw_format = d[9:0];
		end
	endfunction

	// Result coding tracks the current mode per sample
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			result_o <= atw_pkg::CODE_ZERO;
			result_valid_o <= 1'b0;
			bipolar_active_o <= 1'b0;
		end else begin
			result_valid_o <= conv_valid_i;
			bipolar_active_o <= bipolar;
			if (conv_valid_i) begin
				result_o <= atw_format(conv_diff_i, bipolar);
			end
		end
	end
endmodule

// ---- tb/atw_sva.sv ----
// Assertion checker for the two-wire slave interface
module atw_sva (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic sda_oe_o,
	input wire logic signed [10:0] conv_diff_i,
	input wire logic conv_valid_i,
	input wire logic [9:0] result_o,
	input wire logic result_valid_o,
	input wire logic bipolar_active_o,
	input wire logic polarity_select_o,
	input wire logic input_mode_select_o,
	input wire logic hs_mode_o,
	input wire logic bus_busy_o,
	input wire logic read_request_o,
	input wire logic addr_match_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_ack_low;
		sda_oe_o [*8];
	endsequence
	property p_res_lat;
		conv_valid_i |=> result_valid_o;
	endproperty
	a_res_lat: assert property (p_res_lat) else $error("late");
	property p_uni_zero;
		conv_valid_i && !(polarity_select_o && !input_mode_select_o)
			&& conv_diff_i[10] |=> result_o == 10'h000;
	endproperty
	a_uni_zero: assert property (p_uni_zero) else $error("neg");
	property p_bip_map;
		1'b1 |-> bipolar_active_o ==
			($past(polarity_select_o) && !$past(input_mode_select_o));
	endproperty
	a_bip_map: assert property (p_bip_map) else $error("bip");
	property p_ack_hold;
		$rose(sda_oe_o) |-> s_ack_low;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack");
	property p_scl_low;
		$changed(sda_oe_o) |-> !scl_i;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("sda");
	property p_idle_rel;
		!bus_busy_o |-> !sda_oe_o;
	endproperty
	a_idle_rel: assert property (p_idle_rel) else $error("idle");
	property p_match_ack;
		addr_match_o |-> ##[1:40] s_ack_low;
	endproperty
	a_match_ack: assert property (p_match_ack) else $error("m");
	property p_hs_nack;
		$rose(hs_mode_o) |-> bus_busy_o && !sda_oe_o;
	endproperty
	a_hs_nack: assert property (p_hs_nack) else $error("hs");
	property p_hs_stop;
		$fell(bus_busy_o) |-> ##[0:1] !hs_mode_o;
	endproperty
	a_hs_stop: assert property (p_hs_stop) else $error("fs");
	property p_rd_busy;
		$rose(read_request_o) |-> bus_busy_o;
	endproperty
	a_rd_busy: assert property (p_rd_busy) else $error("rd");
endmodule

// ---- tb/atw_master.sv ----
// Bus master model driving the serial clock and pulling the data line
module atw_master (
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic pull_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic start();
		pull_o = 1'b0;
		wt(8);
		scl_o = 1'b1;
		wt(15);
		pull_o = 1'b1;
		wt(15);
		scl_o = 1'b0;
		wt(8);
	endtask
	task automatic stop();
		pull_o = 1'b1;
		wt(8);
		scl_o = 1'b1;
		wt(15);
		pull_o = 1'b0;
		wt(15);
	endtask
	task automatic send(input logic [7:0] b, output logic a);
		for (int i = 8; i >= 0; i--) begin
			pull_o = (i > 0) ? ~b[i-1] : 1'b0;
			wt(8);
			scl_o = 1'b1;
			wt(8);
			if (i == 0)
				a = ~sda_i;
			wt(7);
			scl_o = 1'b0;
			wt(8);
		end
	endtask
endmodule

// ---- tb/atw_slave_tb.sv ----
// Self-checking bench for the two-wire slave interface
module atw_slave_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, reset_n_i, scl_i, sda_i, pull, ack, sda_o, sda_oe_o;
	logic conv_valid_i, result_valid_o, bipolar_active_o, addr_match_o;
	logic polarity_select_o, input_mode_select_o, hs_mode_o;
	logic bus_busy_o, read_request_o;
	logic signed [10:0] conv_diff_i;
	logic [9:0] result_o;
	logic [7:0] setup_byte_o, config_byte_o;
	int num_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	// Pull-up wins unless someone pulls low
	assign sda_i = ~(pull | sda_oe_o);
	atw_slave i_dut (.clock_i, .reset_n_i, .scl_i, .sda_i, .sda_o,
		.sda_oe_o, .conv_diff_i, .conv_valid_i, .result_o, .result_valid_o,
		.bipolar_active_o, .polarity_select_o, .input_mode_select_o,
		.setup_byte_o, .config_byte_o, .hs_mode_o, .bus_busy_o,
		.read_request_o, .addr_match_o);
	atw_master i_m (.clock_i, .sda_i, .scl_o(scl_i), .pull_o(pull));
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] b, input logic ea);
		i_m.send(b, ack);
		chk({9'h000, ack}, {9'h000, ea});
	endtask
	task automatic conv(input logic [10:0] d, input logic [9:0] e);
		conv_diff_i = d;
		conv_valid_i = 1'b1;
		@(negedge clock_i);
		conv_valid_i = 1'b0;
		chk(result_o, e);
		chk({9'h000, result_valid_o}, 10'h001);
		@(negedge clock_i);
		chk({9'h000, result_valid_o}, 10'h000);
	endtask
	// Hang guard, run needs about 4500 cycles
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		reset_n_i = 1'b0;
		conv_valid_i = 1'b0;
		conv_diff_i = 11'h000;
		repeat (10) @(negedge clock_i);
		reset_n_i = 1'b1;
		chk({2'h0, setup_byte_o}, 10'h082);
		chk({8'h00, polarity_select_o, input_mode_select_o}, 10'h001);
		chk({2'h0, config_byte_o}, 10'h001);
		chk({7'h00, hs_mode_o, bus_busy_o, sda_oe_o}, 10'h000);
		i_m.wt(4);
		i_m.start();
		chk({9'h000, bus_busy_o}, 10'h001);
		wr(8'h6C, 1'b1);
		wr(8'h84, 1'b1);
		wr(8'h00, 1'b1);
		chk({2'h0, setup_byte_o}, 10'h084);
		chk({8'h00, polarity_select_o, input_mode_select_o}, 10'h002);
		chk({2'h0, config_byte_o}, 10'h000);
		i_m.stop();
		chk({8'h00, bus_busy_o, sda_o}, 10'h000);
		chk({9'h000, bipolar_active_o}, 10'h001);
		conv(11'h5A8, 10'h200);
		conv(11'h005, 10'h005);
		conv(11'h7FF, 10'h3FF);
		i_m.start();
		wr(8'h6C, 1'b1);
		wr(8'h01, 1'b1);
		i_m.stop();
		conv(11'h2BC, 10'h2BC);
		conv(11'h7FB, 10'h000);
		i_m.start();
		wr(8'h6C, 1'b1);
		wr(8'h00, 1'b1);
		wr(8'h82, 1'b1);
		i_m.stop();
		chk({2'h0, config_byte_o}, 10'h000);
		conv(11'h7FB, 10'h000);
		conv(11'h123, 10'h123);
		i_m.start();
		wr(8'h6E, 1'b0);
		wr(8'h86, 1'b0);
		i_m.stop();
		chk({2'h0, setup_byte_o}, 10'h082);
		i_m.start();
		wr(8'h6C, 1'b1);
		wr(8'h84, 1'b1);
		i_m.stop();
		chk({2'h0, setup_byte_o}, 10'h084);
		chk({2'h0, config_byte_o}, 10'h001);
		chk({9'h000, bipolar_active_o}, 10'h000);
		i_m.start();
		wr(8'h08, 1'b0);
		chk({9'h000, hs_mode_o}, 10'h001);
		i_m.start();
		chk({9'h000, hs_mode_o}, 10'h001);
		wr(8'h6D, 1'b1);
		chk({9'h000, read_request_o}, 10'h001);
		i_m.stop();
		chk({9'h000, hs_mode_o}, 10'h000);
		close_out();
	end
endmodule
bind atw_slave atw_sva i_sva (.clock_i, .reset_n_i, .scl_i, .sda_oe_o,
	.conv_diff_i, .conv_valid_i, .result_o, .result_valid_o,
	.bipolar_active_o, .polarity_select_o, .input_mode_select_o,
	.hs_mode_o, .bus_busy_o, .read_request_o, .addr_match_o);
